// >>> design/pti_core.sv
// Periodic timer interrupt unit: interval counter, enable gating, branch request and return point.
// Assumes an instruction sequencer that supplies the current program address, pulses routine_done
// when the return instruction of any interrupt routine completes, and reports other routines busy.
//
// Functional notes
// - Interrupt repeats every configured 10 to 140 ms.
// - Only active when ladder language selected.
// - Needs configuration enable; uses configured interval.
// - Expiry branches to label in jump register; expiries arriving while one is pending merge into one branch.
// - Resume main program at interrupted address.
// - Label value resolves to branch start address.
// - Status flag follows timer interrupt enable.
// - One routine at a time; others held pending.
// - Disable/enable instructions gate timer interrupt at runtime.
`timescale 1ns/10ps
module pti_core #(
  parameter int unsigned TICK_DIV   = pti_pkg::TICK_CYCLES,
  parameter int unsigned LABELS     = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       running,
  input  wire logic                       cfg_load,
  input  wire logic                       cfg_enable,
  input  wire logic [pti_pkg::INTERVAL_W-1:0] cfg_interval,
  input  wire pti_pkg::pti_lang_e         cfg_lang,
  input  wire logic                       label_def_we,
  input  wire logic [$clog2(LABELS)-1:0]  label_def_num,
  input  wire logic [pti_pkg::ADDR_W-1:0] label_def_addr,
  input  wire logic                       timer_irq_jump_label_reg_we,
  input  wire logic [pti_pkg::LABEL_W-1:0] timer_irq_jump_label_wdata,
  input  wire logic                       interrupt_disable_instruction,
  input  wire logic                       interrupt_enable_instruction,
  input  wire logic [pti_pkg::ADDR_W-1:0] pc,
  input  wire logic                       other_routine_busy,
  input  wire logic                       routine_done,
  output logic                            branch_req,
  output logic [pti_pkg::ADDR_W-1:0]      branch_addr,
  output logic                            return_req,
  output logic [pti_pkg::ADDR_W-1:0]      return_addr,
  output logic                            timer_irq_active_flag,
  output logic                            in_service,
  output logic                            pending
);
  import pti_pkg::*;

  localparam int unsigned LW = $clog2(LABELS);

  ////////////////////////////////////////////////////////////////////////////
  // Settings latched only on program download, so edits do not act early.

  logic                  set_enable;
  logic [INTERVAL_W-1:0] set_interval;
  pti_lang_e             set_lang;
  logic                  rt_enable;
  logic [LABEL_W-1:0]    timer_irq_jump_label_reg;
  logic [ADDR_W-1:0]     label_table [LABELS];

  function automatic logic [INTERVAL_W-1:0] clamp_interval(input logic [INTERVAL_W-1:0] v);
    if (v < INTERVAL_W'(INTERVAL_MIN_MS)) begin
      return INTERVAL_W'(INTERVAL_MIN_MS);
    end else if (v > INTERVAL_W'(INTERVAL_MAX_MS)) begin
      return INTERVAL_W'(INTERVAL_MAX_MS);
    end
    return v;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_enable   <= 1'b0;
      set_interval <= INTERVAL_RST;
      set_lang     <= PTI_LANG_OTHER_A;
    end else if (cfg_load) begin
      set_enable   <= cfg_enable;
      set_interval <= clamp_interval(cfg_interval);
      set_lang     <= cfg_lang;
    end
  end

  // Runtime enable: normally on while running, toggled by the two instructions.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rt_enable <= 1'b1;
    end else if (cfg_load) begin
      rt_enable <= 1'b1;
    end else if (interrupt_disable_instruction) begin
      rt_enable <= 1'b0;
    end else if (interrupt_enable_instruction) begin
      rt_enable <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_irq_jump_label_reg <= '0;
    end else if (timer_irq_jump_label_reg_we) begin
      timer_irq_jump_label_reg <= timer_irq_jump_label_wdata;
    end
  end

  // Label table filled by the label instruction at download time; no reset needed for memory.
  always_ff @(posedge clk) begin
    if (label_def_we) begin
      label_table[label_def_num] <= label_def_addr;
    end
  end

  wire armed = running && set_enable && (set_lang == PTI_LANG_LADDER) && rt_enable;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_irq_active_flag <= 1'b0;
    end else begin
      timer_irq_active_flag <= set_enable && rt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval counter on the millisecond tick.

  logic                  tick;
  logic [INTERVAL_W-1:0] ms_left;
  wire                   expire = armed && tick && (ms_left == INTERVAL_W'(1));

  pti_tick #(
    .DIV  (TICK_DIV)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .run  (armed),
    .tick (tick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_left <= INTERVAL_RST;
    end else if (!armed || expire) begin
      ms_left <= set_interval;
    end else if (tick) begin
      ms_left <= ms_left - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service sequencing: one routine at a time, a late request waits.

  pti_state_e       state;
  pti_state_e       next_state;
  logic [ADDR_W-1:0] saved_pc;

  wire can_enter = !other_routine_busy && (state == PTI_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (expire) begin
      pending <= 1'b1;
    end else if (state == PTI_ENTER || !armed) begin
      pending <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PTI_IDLE: begin
        if (pending && armed && can_enter) begin
          next_state = PTI_ENTER;
        end
      end
      PTI_ENTER: next_state = PTI_SERVICE;
      PTI_SERVICE: begin
        if (routine_done) begin
          next_state = PTI_IDLE;
        end
      end
      default: next_state = PTI_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PTI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saved_pc    <= '0;
      branch_addr <= '0;
      return_addr <= '0;
    end else if (state == PTI_IDLE && next_state == PTI_ENTER) begin
      saved_pc    <= pc;
      branch_addr <= label_table[timer_irq_jump_label_reg[LW-1:0]];
    end else if (state == PTI_SERVICE && routine_done) begin
      return_addr <= saved_pc;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      return_req <= 1'b0;
    end else begin
      return_req <= (state == PTI_SERVICE) && routine_done;
    end
  end

  assign branch_req = (state == PTI_ENTER);
  assign in_service = (state != PTI_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_enter;
    state == PTI_IDLE && next_state == PTI_ENTER;
  endsequence

  a_branch_follows: assert property (@(posedge clk) disable iff (rst)
    s_enter |=> branch_req ##1 !branch_req)
    else $error("branch request not one cycle after entry");

  a_saved_point: assert property (@(posedge clk) disable iff (rst)
    s_enter |=> saved_pc == $past(pc))
    else $error("interrupted address not captured at entry");

  a_return_point: assert property (@(posedge clk) disable iff (rst)
    state == PTI_SERVICE && routine_done |=> return_req && return_addr == $past(saved_pc))
    else $error("return address differs from interrupted address");

  a_lang_gate: assert property (@(posedge clk) disable iff (rst)
    set_lang != PTI_LANG_LADDER |-> !expire)
    else $error("expiry with non-ladder language");

  a_enable_gate: assert property (@(posedge clk) disable iff (rst)
    !set_enable |-> !expire)
    else $error("expiry while disabled");

  a_status_flag: assert property (@(posedge clk) disable iff (rst)
    ##1 timer_irq_active_flag == $past(set_enable && rt_enable))
    else $error("status flag does not follow enable");

  a_single_routine: assert property (@(posedge clk) disable iff (rst)
    other_routine_busy && state == PTI_IDLE |=> state != PTI_ENTER)
    else $error("entered during another routine");

  a_disable_instr: assert property (@(posedge clk) disable iff (rst)
    interrupt_disable_instruction && !cfg_load |=> !rt_enable ##0 !armed)
    else $error("disable instruction ignored");

  a_reload: assert property (@(posedge clk) disable iff (rst)
    expire |=> ms_left == $past(set_interval))
    else $error("interval not reloaded on expiry");

  a_range: assert property (@(posedge clk) disable iff (rst)
    set_interval >= INTERVAL_W'(INTERVAL_MIN_MS) && set_interval <= INTERVAL_W'(INTERVAL_MAX_MS))
    else $error("interval outside allowed range");
endmodule

// >>> design/pti_pkg.sv
// Package for the periodic timer interrupt unit: timing constants, widths and states.
// Assumes a 50 MHz system clock; the instruction sequencer outside uses these widths too.
package pti_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned INTERVAL_MIN_MS = 10;
  localparam int unsigned INTERVAL_MAX_MS = 140;
  localparam int unsigned INTERVAL_W      = 8;
  localparam int unsigned LABEL_W         = 16;
  localparam int unsigned ADDR_W          = 16;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 8'h0a;

  typedef enum logic [1:0] {
    PTI_LANG_LADDER,
    PTI_LANG_OTHER_A,
    PTI_LANG_OTHER_B,
    PTI_LANG_OTHER_C
  } pti_lang_e;

  typedef enum {
    PTI_IDLE,
    PTI_ENTER,
    PTI_SERVICE
  } pti_state_e;
endpackage

// >>> design/pti_tick.sv
// Millisecond tick divider for the periodic timer interrupt unit.
// Assumes clk runs at the rate given in the package; the tick is a one-cycle pulse.
`timescale 1ns/10ps
module pti_tick #(
  parameter int unsigned DIV = pti_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  import pti_pkg::*;

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  wire           wrap = (count == LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!run || wrap) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick = run && wrap;
endmodule

// >>> bench/periodic_timer_interrupt_test.sv
// Self-checking bench for the periodic timer interrupt unit.
// Assumes pti_pkg and pti_core are compiled first; the ms tick is shortened to 4 cycles.
`timescale 1ns/10ps
module periodic_timer_interrupt_test;
  import pti_pkg::*;
  localparam int unsigned DIV = 4;
  logic                  clk, rst, running, cfg_load, cfg_enable, label_def_we, jump_we, dis, ena, busy, done;
  logic                  branch_req, return_req, flag, in_service, pending;
  logic [INTERVAL_W-1:0] cfg_interval;
  pti_lang_e             cfg_lang;
  logic [3:0]            label_def_num;
  logic [LABEL_W-1:0]    jump_data;
  logic [ADDR_W-1:0]     label_def_addr, pc, branch_addr, return_addr, exp_ret, pc_prev;
  int                    err_count, checks, cyc, last_br, gap;

  pti_core #(.TICK_DIV(DIV), .LABELS(16)) dut (.clk(clk), .rst(rst), .running(running), .cfg_load(cfg_load),
    .cfg_enable(cfg_enable), .cfg_interval(cfg_interval), .cfg_lang(cfg_lang), .label_def_we(label_def_we),
    .label_def_num(label_def_num), .label_def_addr(label_def_addr), .timer_irq_jump_label_reg_we(jump_we),
    .timer_irq_jump_label_wdata(jump_data), .interrupt_disable_instruction(dis),
    .interrupt_enable_instruction(ena), .pc(pc), .other_routine_busy(busy), .routine_done(done),
    .branch_req(branch_req), .branch_addr(branch_addr), .return_req(return_req), .return_addr(return_addr),
    .timer_irq_active_flag(flag), .in_service(in_service), .pending(pending));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // A moving program address makes a stale or early return point visible.
  always @(posedge clk) pc <= rst ? 16'h0000 : pc + 16'h0001;

  // Branch spacing and the address interrupted are taken at the falling edge, where outputs are settled.
  always @(negedge clk) begin
    cyc++;
    if (branch_req === 1'h1) begin
      gap = cyc - last_br;
      last_br = cyc;
      exp_ret = pc_prev;
    end
    pc_prev = pc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cfg(input logic en, input logic [7:0] iv, input pti_lang_e lang, input logic run);
    @(posedge clk);
    cfg_enable <= en;
    cfg_interval <= iv;
    cfg_lang <= lang;
    running <= run;
    cfg_load <= 1'h1;
    @(posedge clk);
    cfg_load <= 1'h0;
  endtask

  task automatic wait_br(input int max, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (branch_req !== 1'h1 && n < max);
    #1;
  endtask

  task automatic service();
    @(posedge clk) done <= 1'h1;
    @(posedge clk) done <= 1'h0;
    @(negedge clk);
    chk("return_req", 1'h1, return_req);
    chk("return_addr", exp_ret, return_addr);
    chk("in_service", 1'h0, in_service);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_period(input logic [7:0] iv, input int ms, input logic [3:0] lbl, input logic [15:0] a);
    int n;
    @(posedge clk);
    label_def_we <= 1'h1;
    label_def_num <= lbl;
    label_def_addr <= a;
    jump_we <= 1'h1;
    jump_data <= {12'h001, lbl};
    @(posedge clk);
    label_def_we <= 1'h0;
    jump_we <= 1'h0;
    cfg(1'h1, iv, PTI_LANG_LADDER, 1'h1);
    wait_br(ms * DIV + 10, n);
    chk("branch_req", 1'h1, branch_req);
    chk("in_service", 1'h1, in_service);
    chk("branch_addr", a, branch_addr);
    chk("active_flag", 1'h1, flag);
    service();
    wait_br(ms * DIV + 10, n);
    chk("interval", 16'(ms * DIV), 16'(gap));
    service();
  endtask

  // Other languages, no enable and a stopped program must all stay silent.
  task automatic t_gate();
    int n;
    for (int k = 0; k < 5; k++) begin
      cfg(k != 3, 8'h0a, (k < 3) ? pti_lang_e'(k + 1) : PTI_LANG_LADDER, k != 4);
      // The status flag is registered one edge after the settings it follows.
      repeat (2) @(negedge clk);
      chk("active_flag", k != 3, flag);
      wait_br(100, n);
      chk("branch_req", 1'h0, branch_req);
    end
  endtask

  task automatic t_runtime();
    int n;
    cfg(1'h1, 8'h0a, PTI_LANG_LADDER, 1'h1);
    @(posedge clk) dis <= 1'h1;
    @(posedge clk) dis <= 1'h0;
    cfg_enable <= 1'h0;
    repeat (2) @(negedge clk);
    chk("active_flag", 1'h0, flag);
    wait_br(100, n);
    chk("branch_req", 1'h0, branch_req);
    @(posedge clk) ena <= 1'h1;
    @(posedge clk) ena <= 1'h0;
    repeat (2) @(negedge clk);
    chk("active_flag", 1'h1, flag);
    wait_br(10 * DIV + 10, n);
    chk("branch_req", 1'h1, branch_req);
    service();
  endtask

  task automatic t_busy();
    int n;
    cfg(1'h1, 8'h0a, PTI_LANG_LADDER, 1'h1);
    @(posedge clk) busy <= 1'h1;
    wait_br(100, n);
    chk("branch_req", 1'h0, branch_req);
    chk("pending", 1'h1, pending);
    @(posedge clk) busy <= 1'h0;
    wait_br(4, n);
    chk("branch_req", 1'h1, branch_req);
    service();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, running, cfg_load, cfg_enable, label_def_we, jump_we, dis, ena, busy, done} = 10'h200;
    {cfg_interval, label_def_num, jump_data, label_def_addr} = '0;
    cfg_lang = PTI_LANG_LADDER;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_period(8'h0a, 10, 4'h3, 16'h0bee);
    t_period(8'h05, 10, 4'h7, 16'h1a20);
    t_period(8'h8c, 140, 4'hc, 16'h2f00);
    t_period(8'hc8, 140, 4'h0, 16'h0004);
    t_gate();
    t_runtime();
    t_busy();
    end_of_test();
  end

  // The tests need about 3200 cycles; over six times that means a hang.
  initial begin
    #(20 * 20000);
    err_count++;
    end_of_test();
  end
endmodule
